// >>> aos_sequencer.sv
// Output sequencer of a delta-sigma converter, internal serial clock modes:
// continuous (select held low) and autostart (capacitor on select pin).
// Assumes reset is synchronous to mclk, linkClk is a free-running internal
// oscillator, and the select threshold comparator arrives as a digital level.
//
// Summary of operation
// R1 - Mode chosen at end of power-on wait by sampling serial clock pin.
// R2 - Pull-up on serial clock during power-on; low pin selects external clocking.
// R3 - During conversion serial clock and data output both driven high.
// R4 - On completion serial clock and data go low and device sleeps.
// R5 - Continuous mode: sleep at least half a serial clock period, then shift.
// R6 - Output cycle starts at first rising edge, ends after the 32nd.
// R7 - Data changes on falling edges; generated clock driven onto the pin.
// R8 - Host samples on rising edges: done bit first, last bit at 32nd.
// R9 - After 32nd rising edge data goes high; clock held high while converting.
// R10 - Host may tie select low permanently; no host prompt starts conversions.
// R11 - Autostart: select pin held high by weak pull-up during conversion.
// R12 - Autostart: on completion sleep and enable small discharge current on select.
// R13 - Autostart: select below threshold starts the 32-bit output cycle.
// R14 - Autostart: after 32nd rising edge pull select high, convert again.
// R15 - Internal clocking reselected at each crossing; clock pull-up on while discharging.
// R16 - Host never pulls serial clock low while select capacitor discharges.
// R17 - Result copied into static shift register when done indicator falls.
// R18 - Serial clock pull-up disabled whenever the serial clock pin is low; code keeps it on while settling after release.
// R19 - Conversion length and clock period are parameters; threshold is one input.
// R20 - Bits: done bit first, then 31 result bits, no gaps.
`timescale 1ns/10ps
`include "aos_params.svh"

module aos_sequencer #(
   parameter int POR_CYCLES = `AOS_POR_CYCLES,     // Power-on wait in mclk cycles
   parameter int CONV_CYCLES = `AOS_CONV_CYCLES,   // Conversion length, mclk cycles
   parameter int SCK_HALF = `AOS_SCK_HALF_LINK     // Serial clock half period, link cycles
) (
   input  wire logic                        mclk,             // Main clock, 100 MHz
   input  wire logic                        reset,            // Synchronous, active high
   input  wire logic                        linkClk,          // Internal oscillator clock
   input  wire logic [`AOS_RESULT_BITS-1:0] resultIn,         // Converter result, mclk domain
   input  wire logic                        csBelowThr,       // Select pin below threshold
   input  wire logic                        sckIn,            // Serial clock pin level
   output logic                             sckOut,           // Serial clock pin drive value
   output logic                             sckOeN,           // Serial clock drive enable, low
   output logic                             sckPullupEn,      // Weak pull-up on serial clock
   output logic                             serialDataOut,    // Serial data output value
   output logic                             serialDataOeN,    // Data output enable, low
   output logic                             csPullupEn,       // Weak pull-up on select pin
   output logic                             csDischargeEn,    // Discharge current on select
   output logic                             internalMode      // Internal clocking selected
);

   // Parameters the counters cannot serve; the half-period counter is 16 bits wide
   if (POR_CYCLES < 1 || CONV_CYCLES < 1 || SCK_HALF < 1 || SCK_HALF > 65536)
   begin : badCounts
      $error("aos_sequencer: counts out of range");
   end

   aos_pkg::aos_main_state_t mainState_q;
   logic [31:0]                  mainCnt_q;
   logic                         autoMode_q;
   logic                         startTgl_q;
   logic                         convBusy_q;
   logic                         sckPullupEn_q;
   logic                         csPullupEn_q;
   logic                         csDischargeEn_q;
   logic                         internalMode_q;
   logic [`AOS_RESULT_BITS-1:0]  result_q;
   logic                         sckMeta_q;
   logic                         sckSync_q;
   logic                         csMeta_q;
   logic                         csSync_q;
   logic                         doneMeta_q;
   logic                         doneSync_q;
   logic                         doneSeen_q;
   logic                         doneTgl_q;
   logic                         doneEvent;
   logic                         settling;

   // Pins pass two flops before any logic looks at them
   always_ff @(posedge mclk)
   begin
      sckMeta_q  <= sckIn;
      sckSync_q  <= sckMeta_q;
      csMeta_q   <= csBelowThr;  // R19
      csSync_q   <= csMeta_q;
      doneMeta_q <= doneTgl_q;
      doneSync_q <= doneMeta_q;
   end

   // Frame-done toggle from the link side, turned into a pulse
   always_ff @(posedge mclk)
   begin
      if (reset)
         doneSeen_q <= 1'h0;
      else
         doneSeen_q <= doneSync_q;
   end
   assign doneEvent = doneSync_q ^ doneSeen_q;

   // Pull-up needs time after sclk is released before a low pin means a driver
   assign settling = (mainState_q == aos_pkg::MAIN_WAIT) &&
                     (mainCnt_q < 32'(`AOS_RELEASE_SETTLE));

   // Main sequence: power-on, convert, sleep, output, repeat
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         mainState_q     <= aos_pkg::MAIN_POR;
         mainCnt_q       <= 32'h0;
         autoMode_q      <= 1'h0;
         startTgl_q      <= 1'h0;
         convBusy_q      <= `AOS_EOC_BUSY_LEVEL;
         csPullupEn_q    <= 1'h0;
         csDischargeEn_q <= 1'h0;
         internalMode_q  <= 1'h0;
      end
      else
      begin
         unique case (mainState_q)
            aos_pkg::MAIN_POR:
            begin
               mainCnt_q <= mainCnt_q + 32'h1;
               if (mainCnt_q == 32'(POR_CYCLES - 1))
               begin
                  mainCnt_q      <= 32'h0;
                  internalMode_q <= sckSync_q;                      // R1 R2
                  mainState_q    <= sckSync_q ? aos_pkg::MAIN_CONV : aos_pkg::MAIN_EXT;
                  csPullupEn_q   <= sckSync_q;
               end
            end
            aos_pkg::MAIN_CONV:
            begin
               mainCnt_q <= mainCnt_q + 32'h1;
               if (mainCnt_q == 32'(CONV_CYCLES - 1))                   // R19
               begin
                  // Select still high at completion means a capacitor is fitted
                  mainCnt_q       <= 32'h0;
                  convBusy_q      <= 1'h0;                         // R4
                  autoMode_q      <= !csSync_q;
                  csPullupEn_q    <= 1'h0;                         // R12
                  csDischargeEn_q <= !csSync_q;                    // R12
                  mainState_q     <= aos_pkg::MAIN_WAIT;
               end
            end
            aos_pkg::MAIN_WAIT:
            begin
               if (settling)
                  mainCnt_q <= mainCnt_q + 32'h1;
               if (csSync_q && !settling)
               begin
                  csDischargeEn_q <= 1'h0;
                  if (autoMode_q && !sckSync_q)
                  begin
                     internalMode_q <= 1'h0;                       // R15
                     mainState_q    <= aos_pkg::MAIN_EXT;
                  end
                  else
                  begin
                     startTgl_q  <= !startTgl_q;                   // R13 R10
                     mainState_q <= aos_pkg::MAIN_OUT;
                  end
               end
            end
            aos_pkg::MAIN_OUT:
            begin
               if (doneEvent)
               begin
                  mainCnt_q    <= 32'h0;
                  convBusy_q   <= 1'h1;                            // R9
                  csPullupEn_q <= 1'h1;                            // R14 R11
                  mainState_q  <= aos_pkg::MAIN_CONV;
               end
            end
            aos_pkg::MAIN_EXT:
            begin
               // External clocking modes are served elsewhere; sequencer parks
               mainCnt_q <= 32'h0;
            end
         endcase
      end
   end

   // Result frozen when the done indicator falls; stable for the link side
   always_ff @(posedge mclk)
   begin
      if (reset)
         result_q <= '0;
      else if (mainState_q == aos_pkg::MAIN_CONV && mainCnt_q == 32'(CONV_CYCLES - 1))
         result_q <= resultIn;                                     // R17
   end

   // Serial clock pull-up: on in power-on and discharge, off while pin is low outside the settle window
   always_ff @(posedge mclk)
   begin
      if (reset)
         sckPullupEn_q <= 1'h1;
      else
         sckPullupEn_q <= (mainState_q == aos_pkg::MAIN_POR ||
                           (mainState_q == aos_pkg::MAIN_WAIT && autoMode_q)) &&
                          (sckSync_q || settling);                  // R2 R15 R18
   end

   assign sckPullupEn   = sckPullupEn_q;
   assign csPullupEn    = csPullupEn_q;
   assign csDischargeEn = csDischargeEn_q;
   assign internalMode  = internalMode_q;

   // Link side: reset and levels from mclk cross through two flops
   aos_pkg::aos_link_state_t linkState_q;
   logic                          rstMeta_q;
   logic                          linkRst_q;
   logic                          startMeta_q;
   logic                          startSync_q;
   logic                          startSeen_q;
   logic                          busyMeta_q;
   logic                          busySync_q;
   logic                          busySeen_q;
   logic                          intMeta_q;
   logic                          intSync_q;
   logic                          relMeta_q;
   logic                          relSync_q;
   logic                          sck_q;
   logic                          sckOeN_q;
   logic                          dat_q;
   logic                          datOeN_q;
   logic [`AOS_FRAME_BITS-1:0]    shift_q;
   logic [5:0]                    bitCnt_q;
   logic [15:0]                   halfCnt_q;
   logic                          halfDone;

   always_ff @(posedge linkClk)
   begin
      rstMeta_q   <= reset;
      linkRst_q   <= rstMeta_q;
      startMeta_q <= startTgl_q;
      startSync_q <= startMeta_q;
      busyMeta_q  <= convBusy_q;
      busySync_q  <= busyMeta_q;
      intMeta_q   <= internalMode_q;
      intSync_q   <= intMeta_q;
      relMeta_q   <= csDischargeEn_q;  // A flop, so no decode glitch crosses
      relSync_q   <= relMeta_q;
   end

   assign halfDone = halfCnt_q == 16'(SCK_HALF - 1);

   // Pin enables: driven only in internal mode, clock released while discharging
   always_ff @(posedge linkClk)
   begin
      if (linkRst_q)
      begin
         sckOeN_q <= 1'h1;
         datOeN_q <= 1'h1;
      end
      else
      begin
         // Driven again once a start is seen, so the sleep half-period shows low
         sckOeN_q <= !intSync_q || (relSync_q && linkState_q == aos_pkg::LINK_IDLE &&
                     startSync_q == startSeen_q);                          // R7 R15
         datOeN_q <= !intSync_q;
      end
   end

   // Frame sequencer on the link clock
   always_ff @(posedge linkClk)
   begin
      if (linkRst_q)
      begin
         linkState_q <= aos_pkg::LINK_IDLE;
         startSeen_q <= 1'h0;
         busySeen_q  <= `AOS_EOC_BUSY_LEVEL;
         doneTgl_q   <= 1'h0;
         sck_q       <= 1'h1;
         dat_q       <= 1'h1;
         shift_q     <= '0;
         bitCnt_q    <= 6'h0;
         halfCnt_q   <= 16'h0;
      end
      else
      begin
         busySeen_q <= busySync_q;
         unique case (linkState_q)
            aos_pkg::LINK_IDLE:
            begin
               if (busySync_q != busySeen_q)
               begin
                  sck_q <= busySync_q;                             // R3 R4
                  dat_q <= busySync_q;                             // R3 R4
               end
               if (startSync_q != startSeen_q)
               begin
                  startSeen_q <= startSync_q;
                  shift_q     <= {`AOS_DONE_BIT_VALUE, result_q};  // R17 R20
                  dat_q       <= `AOS_DONE_BIT_VALUE;              // R20
                  sck_q       <= 1'h0;
                  halfCnt_q   <= 16'h0;
                  linkState_q <= aos_pkg::LINK_SLEEP;
               end
            end
            aos_pkg::LINK_SLEEP:
            begin
               // Half a serial period of sleep before the first rising edge
               halfCnt_q <= halfCnt_q + 16'h1;
               if (halfDone)
               begin
                  halfCnt_q   <= 16'h0;
                  sck_q       <= 1'h1;                             // R5 R6
                  bitCnt_q    <= 6'h1;
                  linkState_q <= aos_pkg::LINK_SHIFT;
               end
            end
            aos_pkg::LINK_SHIFT:
            begin
               halfCnt_q <= halfCnt_q + 16'h1;
               if (halfDone && sck_q)
               begin
                  halfCnt_q <= 16'h0;
                  sck_q     <= 1'h0;
                  dat_q     <= shift_q[`AOS_FRAME_BITS-2];         // R7 R20
                  shift_q   <= {shift_q[`AOS_FRAME_BITS-2:0], 1'h0};
               end
               else if (halfDone)
               begin
                  halfCnt_q <= 16'h0;
                  sck_q     <= 1'h1;
                  bitCnt_q  <= bitCnt_q + 6'h1;
                  if (bitCnt_q == 6'(`AOS_FRAME_BITS - 1))
                  begin
                     // Last edge: data high, clock stays high, conversion restarts
                     dat_q       <= 1'h1;                          // R6 R9 R14
                     doneTgl_q   <= !doneTgl_q;
                     linkState_q <= aos_pkg::LINK_IDLE;
                  end
               end
            end
         endcase
      end
   end

   assign sckOut        = sck_q;
   assign sckOeN        = sckOeN_q;
   assign serialDataOut = dat_q;
   assign serialDataOeN = datOeN_q;

   // Checks on the main clock
   modeSelect_a: assert property (@(posedge mclk) disable iff (reset) // R1
      (mainState_q == aos_pkg::MAIN_POR && mainCnt_q == 32'(POR_CYCLES - 1))
      |=> internalMode_q == $past(sckSync_q))
      else $error("mode not taken from serial clock pin at power-on end");
   porLowExt_a: assert property (@(posedge mclk) disable iff (reset) // R2
      (mainState_q == aos_pkg::MAIN_POR && mainCnt_q == 32'(POR_CYCLES - 1) && !sckSync_q)
      |=> mainState_q == aos_pkg::MAIN_EXT)
      else $error("low clock pin did not select external clocking");
   convPull_a: assert property (@(posedge mclk) disable iff (reset) // R11
      mainState_q == aos_pkg::MAIN_CONV |-> csPullupEn_q && !csDischargeEn_q)
      else $error("select pull-up not held during conversion");
   sleepDis_a: assert property (@(posedge mclk) disable iff (reset) // R12
      (mainState_q == aos_pkg::MAIN_CONV && mainCnt_q == 32'(CONV_CYCLES - 1) && !csSync_q)
      |=> mainState_q == aos_pkg::MAIN_WAIT && csDischargeEn_q && !convBusy_q)
      else $error("discharge not enabled on completion");
   crossStart_a: assert property (@(posedge mclk) disable iff (reset) // R13
      (mainState_q == aos_pkg::MAIN_WAIT && csSync_q && !settling && sckSync_q)
      |=> mainState_q == aos_pkg::MAIN_OUT && $changed(startTgl_q))
      else $error("threshold crossing did not start output");
   reselect_a: assert property (@(posedge mclk) disable iff (reset) // R15
      (mainState_q == aos_pkg::MAIN_WAIT && autoMode_q && csSync_q && !settling && !sckSync_q)
      |=> mainState_q == aos_pkg::MAIN_EXT && !internalMode_q)
      else $error("low clock pin at crossing kept internal mode");
   restart_a: assert property (@(posedge mclk) disable iff (reset) // R14
      (mainState_q == aos_pkg::MAIN_OUT && doneEvent)
      |=> mainState_q == aos_pkg::MAIN_CONV && csPullupEn_q && convBusy_q)
      else $error("no new conversion after frame end");
   resultLoad_a: assert property (@(posedge mclk) disable iff (reset) // R17
      $fell(convBusy_q) |-> result_q == $past(resultIn))
      else $error("result not captured at done fall");
   sckPullOff_a: assert property (@(posedge mclk) disable iff (reset) // R18
      (!sckSync_q && !settling) |=> !sckPullupEn_q)
      else $error("clock pull-up left on with pin low");

   // Checks on the link clock
   eocLevel_a: assert property (@(posedge linkClk) disable iff (linkRst_q) // R3 R4
      (linkState_q == aos_pkg::LINK_IDLE && busySync_q != busySeen_q &&
       startSync_q == startSeen_q)
      |=> sck_q == $past(busySync_q) && dat_q == $past(busySync_q))
      else $error("pins do not follow conversion state");
   halfSleep_a: assert property (@(posedge linkClk) disable iff (linkRst_q) // R5
      (linkState_q == aos_pkg::LINK_SHIFT && $past(linkState_q) == aos_pkg::LINK_SLEEP)
      |-> sck_q && !$past(sck_q, SCK_HALF))
      else $error("sleep shorter than half a clock period");
   fallShift_a: assert property (@(posedge linkClk) disable iff (linkRst_q) // R7
      (linkState_q == aos_pkg::LINK_SHIFT && $past(linkState_q) == aos_pkg::LINK_SHIFT &&
       $changed(dat_q)) |-> $fell(sck_q))
      else $error("data changed away from a falling edge");
   frameEnd_a: assert property (@(posedge linkClk) disable iff (linkRst_q) // R6 R9
      (linkState_q == aos_pkg::LINK_SHIFT && halfDone && !sck_q &&
       bitCnt_q == 6'(`AOS_FRAME_BITS - 1))
      |=> linkState_q == aos_pkg::LINK_IDLE && sck_q && dat_q)
      else $error("frame did not end high after 32nd rise");
   doneFirst_a: assert property (@(posedge linkClk) disable iff (linkRst_q) // R20
      linkState_q == aos_pkg::LINK_SLEEP |-> dat_q == `AOS_DONE_BIT_VALUE && !sck_q)
      else $error("done bit not presented first");

   frameDone_c: cover property (@(posedge linkClk) disable iff (linkRst_q)
      linkState_q == aos_pkg::LINK_SHIFT ##1 linkState_q == aos_pkg::LINK_IDLE);
   autoStart_c: cover property (@(posedge mclk) disable iff (reset)
      mainState_q == aos_pkg::MAIN_WAIT && autoMode_q ##1 mainState_q == aos_pkg::MAIN_OUT);
   extSel_c: cover property (@(posedge mclk) disable iff (reset)
      mainState_q == aos_pkg::MAIN_WAIT ##1 mainState_q == aos_pkg::MAIN_EXT);

endmodule

// >>> aos_params.svh
// Timing counts, frame layout and reset values of the output sequencer.
// Assumes a 100 MHz main clock; included by bare name.
`ifndef AOS_PARAMS_SVH
`define AOS_PARAMS_SVH

`define AOS_MCLK_PERIOD_NS   10
`define AOS_POR_TIME_NS      500000
`define AOS_POR_CYCLES       ((`AOS_POR_TIME_NS + `AOS_MCLK_PERIOD_NS - 1) / `AOS_MCLK_PERIOD_NS)
`define AOS_CONV_CYCLES      1000
`define AOS_SCK_HALF_LINK    1
`define AOS_FRAME_BITS       32
`define AOS_RESULT_BITS      31
`define AOS_RELEASE_SETTLE   64
`define AOS_DONE_BIT_VALUE   1'h0
`define AOS_EOC_BUSY_LEVEL   1'h1

`endif

// >>> aos_pkg.sv
// Types shared by the output sequencer.
// Constants live in aos_params.svh.
package aos_pkg;

   // Main-clock sequence: power-on wait, convert, sleep/discharge, shift, external
   typedef enum logic [2:0] {
      MAIN_POR,
      MAIN_CONV,
      MAIN_WAIT,
      MAIN_OUT,
      MAIN_EXT
   } aos_main_state_t;

   // Link-clock sequence: idle, half-period sleep, shifting
   typedef enum logic [1:0] {
      LINK_IDLE,
      LINK_SLEEP,
      LINK_SHIFT
   } aos_link_state_t;

endpackage

// >>> aos_host_model.sv
// Receiving host for the sequencer's serial clock and data pins.
// Assumes resolved pin levels; samples them on the main clock.
`timescale 1ns/10ps

module aos_host_model (
   input  wire logic        mclk,       // Sampling clock
   input  wire logic        reset,      // Clears the receiver
   input  wire logic        sckPin,     // Resolved serial clock pin
   input  wire logic        dataPin,    // Resolved data pin
   output logic [31:0]      frameWord,  // Last whole frame
   output logic [15:0]      frameCount  // Frames received
);
   logic [31:0] shift_q;
   logic [5:0]  bits_q;
   logic [6:0]  hi_q;
   logic        sckPrev_q;
   logic        dataPrev_q;

   // Rising clock edge takes the data seen before it, since data may move on that edge
   always_ff @(posedge mclk)
   begin
      sckPrev_q  <= sckPin;
      dataPrev_q <= dataPin;
      if (reset)
      begin
         bits_q     <= 6'h00;
         hi_q       <= 7'h00;
         frameCount <= 16'h0000;
         frameWord  <= 32'h0000_0000;
      end
      else
      begin
         hi_q <= !sckPin ? 7'h00 : (hi_q < 7'h3F) ? hi_q + 7'h01 : hi_q;
         if (hi_q == 7'h28)
            bits_q <= 6'h00; // A long high means no frame in flight
         else if (sckPin && !sckPrev_q)
         begin
            shift_q <= {shift_q[30:0], dataPrev_q};
            if (bits_q == 6'h1F)
            begin
               frameWord  <= {shift_q[30:0], dataPrev_q};
               frameCount <= frameCount + 16'h0001;
               bits_q     <= 6'h00;
            end
            else
               bits_q <= bits_q + 6'h01;
         end
      end
   end
endmodule

// >>> aos_sequencer_test.sv
// Self-checking bench for the output sequencer: continuous frames,
// autostart with a modelled select capacitor, and a refused reselect.
`timescale 1ns/10ps
`include "aos_params.svh"

module aos_sequencer_test;
   logic                        mclk, reset, linkClk, csBelowThr, extLow;
   logic [`AOS_RESULT_BITS-1:0] resultIn;
   logic                        sckOut, sckOeN, sckPullupEn, serialDataOut;
   logic                        serialDataOeN, csPullupEn, csDischargeEn, internalMode;
   logic                        sckPin, sckKeep, dataPin, dataKeep;
   logic [31:0]                 frameWord;
   logic [15:0]                 frameCount;
   int                          n_fail, checked, cycles;
   logic [30:0] rows [4] = '{31'h0000_0000, 31'h7FFF_FFFF, 31'h5555_5555, 31'h2AAA_AAAA};

   // Pin resolution; a released data line toggles so a stale value never passes
   assign sckPin  = !sckOeN ? sckOut : extLow ? 1'h0 : sckPullupEn ? 1'h1 : sckKeep;
   assign dataPin = !serialDataOeN ? serialDataOut : ~dataKeep;
   always @(posedge mclk)
   begin
      sckKeep  <= sckPin;
      dataKeep <= dataPin;
   end

   aos_sequencer #(.POR_CYCLES(20), .CONV_CYCLES(200), .SCK_HALF(1)) DUT (
      .mclk(mclk), .reset(reset), .linkClk(linkClk), .resultIn(resultIn),
      .csBelowThr(csBelowThr), .sckIn(sckPin), .sckOut(sckOut), .sckOeN(sckOeN),
      .sckPullupEn(sckPullupEn), .serialDataOut(serialDataOut),
      .serialDataOeN(serialDataOeN), .csPullupEn(csPullupEn),
      .csDischargeEn(csDischargeEn), .internalMode(internalMode));

   aos_host_model HOST (.mclk(mclk), .reset(reset), .sckPin(sckPin), .dataPin(dataPin),
      .frameWord(frameWord), .frameCount(frameCount));

   // Two unrelated clocks
   initial
   begin
      mclk = 1'h0;
      forever #5 mclk = ~mclk;
   end
   initial
   begin
      linkClk = 1'h0;
      #37;
      forever #80 linkClk = ~linkClk;
   end

   task automatic cmp1(input logic got, input logic exp);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmpw(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic waitFrame;
      logic [15:0] c;
      int          w;
      c = frameCount;
      w = 0;
      while (frameCount === c && w < 5000)
      begin
         @(posedge mclk);
         w++;
      end
      cmp1(frameCount !== c, 1'h1);
   endtask

   // Sleep of the autostart cycle, then settle time before the crossing
   task automatic waitDischarge;
      int w;
      w = 0;
      while (csDischargeEn !== 1'h1 && w < 3000)
      begin
         @(posedge mclk);
         w++;
      end
      cmp1(csDischargeEn, 1'h1);
      cmp1(csPullupEn, 1'h0);
      repeat (100) @(posedge mclk);
   endtask

   task automatic results;
      if (n_fail == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Cuts a hang short well beyond the expected run length
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_fail++;
         results();
      end
   end

   initial
   begin
      reset = 1'h1;
      csBelowThr = 1'h1;
      extLow = 1'h0;
      resultIn = rows[0];
      repeat (3) @(posedge mclk);
      cmp1(sckPullupEn, 1'h1);
      cmp1(internalMode, 1'h0);
      // Long enough for the link side to see reset too
      repeat (47) @(posedge mclk);
      reset <= 1'h0;
      // Link drivers come up a few link cycles after power-on ends
      repeat (100) @(posedge mclk);
      cmp1(internalMode, 1'h1);
      cmp1(sckPin, 1'h1);
      cmp1(dataPin, 1'h1);
      // Continuous frames, next result offered while the next conversion runs
      for (int i = 0; i < 4; i++)
      begin
         waitFrame();
         cmpw(frameWord, {`AOS_DONE_BIT_VALUE, rows[i]});
         resultIn <= rows[(i + 1) % 4];
         repeat (20) @(posedge mclk);
         cmp1(sckPin, 1'h1);
         cmp1(dataPin, 1'h1);
      end
      // Capacitor charged: conversion ends with select still high
      csBelowThr <= 1'h0;
      resultIn <= rows[2];
      waitDischarge();
      cmp1(sckPullupEn, 1'h1);
      csBelowThr <= 1'h1;
      waitFrame();
      cmpw(frameWord, {`AOS_DONE_BIT_VALUE, rows[2]});
      csBelowThr <= 1'h0;
      repeat (5) @(posedge mclk);
      cmp1(csPullupEn, 1'h1);
      cmp1(csDischargeEn, 1'h0);
      // Far side holds the clock low during discharge: internal mode is lost
      waitDischarge();
      extLow <= 1'h1;
      repeat (70) @(posedge mclk);
      cmp1(sckPullupEn, 1'h0);
      csBelowThr <= 1'h1;
      repeat (10) @(posedge mclk);
      cmp1(internalMode, 1'h0);
      // Reset again with the clock pin held low: external clocking, pull-up off
      reset <= 1'h1;
      repeat (50) @(posedge mclk);
      reset <= 1'h0;
      repeat (40) @(posedge mclk);
      cmp1(internalMode, 1'h0);
      cmp1(sckPullupEn, 1'h0);
      results();
   end
endmodule
